// ---- bench/tb.sv ----
// Self-checking bench for the decimal adjust / decrement-skip slice
module tb
    import dads_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic op_valid = 1'b0;
    logic [1:0] op_code = DADS_OP_NONE;
    logic op_dest = 1'b0;
    logic [7:0] acc_in = 8'h00;
    logic carry_in = 1'b0;
    logic [7:0] file_rdata = 8'h00;
    logic op_ready, acc_we, file_we, carry_we, carry_wdata, fetch_flush, nop_slot;
    logic [7:0] acc_wdata, file_wdata;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [8:0] dadj_vec [5] = '{9'h05A, 9'h04D, 9'h09A, 9'h115, 9'h099};
    logic [7:0] dsz_vec [4] = '{8'h01, 8'h05, 8'h00, 8'h80};

    dads_core i_dut (.ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid),
        .op_code(op_code), .op_dest(op_dest), .acc_in(acc_in), .carry_in(carry_in),
        .file_rdata(file_rdata), .op_ready(op_ready), .acc_we(acc_we),
        .acc_wdata(acc_wdata), .file_we(file_we), .file_wdata(file_wdata),
        .carry_we(carry_we), .carry_wdata(carry_wdata), .fetch_flush(fetch_flush),
        .nop_slot(nop_slot));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Presents one op for one cycle; returns just after the answer edge
    task automatic issue(input logic [1:0] code, input logic dest, input logic [7:0] a,
                         input logic c, input logic [7:0] f);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code <= code;
        op_dest <= dest;
        acc_in <= a;
        carry_in <= c;
        file_rdata <= f;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
    endtask

    // Reference decimal adjust, carry in bit 8
    function automatic logic [8:0] dadj_ref(input logic [7:0] a, input logic c);
        logic [8:0] t;
        t = {1'b0, a};
        if (a[3:0] > 4'h9) t = t + 9'h006;
        if (t[7:4] > 4'h9 || c || t[8]) t = t + 9'h060;
        return {c | t[8], t[7:0]};
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_dadj();
        logic [8:0] e;
        foreach (dadj_vec[i]) begin
            e = dadj_ref(dadj_vec[i][7:0], dadj_vec[i][8]);
            // adjust presented straight after the addition result
            // nothing intervenes between addition and adjust
            issue(DADS_OP_DADJ, 1'b0, dadj_vec[i][7:0], dadj_vec[i][8], 8'h00);
            chk(acc_we, 1'b1);
            chk(carry_we, 1'b1);
            chk(acc_wdata, e[7:0]);
            chk(carry_wdata, e[8]);
            chk(fetch_flush, 1'b0);
        end
        $display("test decimal adjust done");
    endtask

    task automatic t_dsz(input logic dest, input logic [7:0] f);
        logic [7:0] e;
        e = f - 8'h01;
        issue(DADS_OP_DSZ, dest, 8'h33, 1'b0, f);
        chk(acc_we, !dest);
        chk(file_we, dest);
        chk(dest ? file_wdata : acc_wdata, e);
        chk(fetch_flush, e == 8'h00);
        chk(op_ready, e != 8'h00);
        // Refused op while the slot is blocked must leave no write
        op_valid <= 1'b1;
        op_code <= DADS_OP_DADJ;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        #1;
        chk(nop_slot, e == 8'h00);
        chk(acc_we, e != 8'h00);
        chk(op_ready, 1'b1);
        $display("test decrement skip done");
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(op_ready, 1'b1);
        chk(acc_wdata, 8'h00);
        t_dadj();
        for (int d = 0; d < 2; d++) begin
            foreach (dsz_vec[i]) t_dsz(d[0], dsz_vec[i]);
        end
        give_verdict();
    end

    // Run should take well under 300 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end
endmodule

// ---- src/dads_alu.sv ----
// Combinational decimal adjust and decrement unit
module dads_alu
    import dads_pkg::*;
(
    dads_alu_if.alu a
);
    logic [8:0] lo_sum;
    logic [8:0] hi_sum;
    logic [7:0] lo_fix;

    // RULE7 low then high fix
    always_comb begin
        lo_fix = (a.acc[3:0] > DADS_DIGIT_MAX) ? DADS_LO_FIX : DADS_ZERO;
        lo_sum = {1'b0, a.acc} + {1'b0, lo_fix};
        hi_sum = lo_sum;
        if ((lo_sum[7:4] > DADS_DIGIT_MAX) || a.carry || lo_sum[8]) begin
            hi_sum = {1'b0, lo_sum[7:0]} + {1'b0, DADS_HI_FIX};
        end
    end

    assign a.bcd = hi_sum[7:0];
    // Decimal overflow keeps an incoming carry set
    assign a.bcd_carry = hi_sum[8] | lo_sum[8] | a.carry;
    // RULE4 minus one
    assign a.dec = a.file_val - DADS_ONE;
    assign a.dec_zero = (a.file_val == DADS_ONE);
endmodule

// ---- src/dads_alu_if.sv ----
// Operand and result bundle between the core and its arithmetic unit
interface dads_alu_if;
    logic [7:0] acc;
    logic carry;
    logic [7:0] file_val;
    logic [7:0] bcd;
    logic bcd_carry;
    logic [7:0] dec;
    logic dec_zero;

    modport core (output acc, output carry, output file_val,
                  input bcd, input bcd_carry, input dec, input dec_zero);
    modport alu (input acc, input carry, input file_val,
                 output bcd, output bcd_carry, output dec, output dec_zero);
endinterface

// ---- src/dads_core.sv ----
// Execution slice for decimal adjust and decrement-skip-if-zero
module dads_core
    import dads_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [1:0] op_code,
    input wire logic op_dest,
    input wire logic [7:0] acc_in,
    input wire logic carry_in,
    input wire logic [7:0] file_rdata,
    output logic op_ready,
    output logic acc_we,
    output logic [7:0] acc_wdata,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic carry_we,
    output logic carry_wdata,
    output logic fetch_flush,
    output logic nop_slot
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        dads_state_t st;
        logic ready;
        logic acc_we;
        logic [7:0] acc_wdata;
        logic file_we;
        logic [7:0] file_wdata;
        logic carry_we;
        logic carry_wdata;
        logic flush;
        logic nop;
    } dads_regs_t;

    dads_regs_t q_r;
    dads_regs_t q_nxt;
    dads_alu_if alu_bus ();
    logic take;

    assign alu_bus.acc = acc_in;
    assign alu_bus.carry = carry_in;
    assign alu_bus.file_val = file_rdata;

    dads_alu u_alu (
        .a (alu_bus.alu)
    );

    // Request accepted except in the fetch_flush cycle after a zero decrement; the no-op slot that follows accepts again
    assign take = op_valid && q_r.ready;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        q_nxt = q_r;
        q_nxt.acc_we = 1'b0;
        q_nxt.file_we = 1'b0;
        q_nxt.carry_we = 1'b0;
        q_nxt.flush = 1'b0;
        q_nxt.nop = 1'b0;
        q_nxt.ready = 1'b1;
        q_nxt.st = DADS_ST_RUN;
        unique case (q_r.st)
            DADS_ST_RUN: begin
                if (take && op_code == DADS_OP_DADJ) begin
                    // RULE1 write back BCD
                    // Trusts acc_in and carry_in to hold the addition result
                    q_nxt.acc_we = 1'b1;
                    q_nxt.acc_wdata = alu_bus.bcd;
                    q_nxt.carry_we = 1'b1;
                    q_nxt.carry_wdata = alu_bus.bcd_carry;
                end else if (take && op_code == DADS_OP_DSZ) begin
                    // RULE4 destination select
                    if (op_dest == DADS_DEST_ACC) begin
                        q_nxt.acc_we = 1'b1;
                        q_nxt.acc_wdata = alu_bus.dec;
                    end else begin
                        q_nxt.file_we = 1'b1;
                        q_nxt.file_wdata = alu_bus.dec;
                    end
                    // RULE5 discard prefetch on zero
                    if (alu_bus.dec_zero) begin
                        q_nxt.flush = 1'b1;
                        q_nxt.ready = 1'b0;
                        q_nxt.st = DADS_ST_NOP;
                    end
                end
            end
            DADS_ST_NOP: begin
                // RULE6 second cycle is the no-op slot
                q_nxt.nop = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            q_r <= '{st: DADS_ST_RUN, ready: 1'b1, acc_wdata: DADS_ZERO,
                     file_wdata: DADS_ZERO, default: 1'b0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign op_ready = q_r.ready;
    assign acc_we = q_r.acc_we;
    assign acc_wdata = q_r.acc_wdata;
    assign file_we = q_r.file_we;
    assign file_wdata = q_r.file_wdata;
    assign carry_we = q_r.carry_we;
    assign carry_wdata = q_r.carry_wdata;
    assign fetch_flush = q_r.flush;
    assign nop_slot = q_r.nop;

    // ****************************************
    // Checks
    // ****************************************
    property p_dadj_write;
        @(posedge ref_clk) disable iff (!resetn)
        (op_valid && op_ready && op_code == DADS_OP_DADJ) |=>
            acc_we && carry_we && !file_we && !fetch_flush;
    endproperty
    a_dadj_write: assert property (p_dadj_write) // RULE1
        else $error("decimal adjust did not write accumulator and carry");

    // Low fix alone: high nibble stays below ten, so no carry
    property p_dadj_value;
        @(posedge ref_clk) disable iff (!resetn)
        (op_valid && op_ready && op_code == DADS_OP_DADJ
         && acc_in == 8'h5A && !carry_in) |=> acc_wdata == 8'h60 && !carry_wdata;
    endproperty
    a_dadj_value: assert property (p_dadj_value) // RULE7
        else $error("decimal adjust of 5A gave wrong result");

    property p_dec_dest;
        @(posedge ref_clk) disable iff (!resetn)
        (op_valid && op_ready && op_code == DADS_OP_DSZ) |=>
            (file_we == $past(op_dest)) && (acc_we != $past(op_dest))
            && ((acc_we ? acc_wdata : file_wdata) == $past(file_rdata) - 8'h01);
    endproperty
    a_dec_dest: assert property (p_dec_dest) // RULE4
        else $error("decrement wrote wrong target or value");

    property p_skip_flush;
        @(posedge ref_clk) disable iff (!resetn)
        (op_valid && op_ready && op_code == DADS_OP_DSZ) |=>
            fetch_flush == ($past(file_rdata) == 8'h01);
    endproperty
    a_skip_flush: assert property (p_skip_flush) // RULE5
        else $error("prefetch flush does not match zero result");

    property p_skip_len;
        @(posedge ref_clk) disable iff (!resetn)
        fetch_flush |-> !op_ready ##1 (nop_slot && op_ready);
    endproperty
    a_skip_len: assert property (p_skip_len) // RULE6
        else $error("skip did not take exactly one extra cycle");

    property p_noskip_len;
        @(posedge ref_clk) disable iff (!resetn)
        (acc_we || file_we) && !fetch_flush |-> op_ready;
    endproperty
    a_noskip_len: assert property (p_noskip_len) // RULE6
        else $error("nonzero decrement stalled the pipeline");
endmodule

// ---- src/dads_pkg.sv ----
// Shared constants and types for the decimal adjust / decrement-skip slice
// ****************************************
// Notes on behaviour
// RULE1: Decimal adjust rewrites accumulator as packed BCD and updates carry.
// RULE2: Software issues decimal adjust right after the addition it corrects.
// RULE3: Software masks interrupts around the addition and decimal adjust pair.
// RULE4: Decrement-skip subtracts one; dest 0 to accumulator, 1 to file register.
// RULE5: Zero result discards the prefetched instruction and runs a no-op slot.
// RULE6: Decrement-skip takes one cycle, or two when the skip is taken.
// RULE7: Add 0x06 if low nibble over nine, 0x60 if high over nine or carry.
// ****************************************
package dads_pkg;
    localparam int DADS_DATA_W = 8;
    localparam logic [3:0] DADS_DIGIT_MAX = 4'h9;
    localparam logic [7:0] DADS_LO_FIX = 8'h06;
    localparam logic [7:0] DADS_HI_FIX = 8'h60;
    localparam logic [7:0] DADS_ONE = 8'h01;
    localparam logic [7:0] DADS_ZERO = 8'h00;
    localparam logic DADS_DEST_ACC = 1'b0;
    localparam logic DADS_DEST_FILE = 1'b1;
    localparam logic [1:0] DADS_OP_NONE = 2'h0;
    localparam logic [1:0] DADS_OP_DADJ = 2'h1;
    localparam logic [1:0] DADS_OP_DSZ = 2'h2;
    localparam int DADS_SKIP_CYCLES = 2;

    typedef enum logic [1:0] {
        DADS_ST_RUN = 2'b01,
        DADS_ST_NOP = 2'b10
    } dads_state_t;
endpackage
